// ---- shared/cbs_params.svh ----
`ifndef CBS_PARAMS_SVH
`define CBS_PARAMS_SVH

// ---------------------------------------------------------------
// Configuration offsets
// ---------------------------------------------------------------
`define CBS_OFF_CAP      8'h14
`define CBS_OFF_STAT     8'h16
`define CBS_OFF_UPBUS    8'h18
`define CBS_OFF_CBBUS    8'h19
`define CBS_OFF_SUBBUS   8'h1a
`define CBS_OFF_PM0      8'ha0
`define CBS_OFF_PM1      8'ha4

// ---------------------------------------------------------------
// Reset and fixed values
// ---------------------------------------------------------------
`define CBS_CAP_VAL      8'ha0
`define CBS_STAT_RST     16'h0200
`define CBS_BUS_RST      8'h00
`define CBS_SEL_TIMING   2'h1

// ---------------------------------------------------------------
// Field positions in the downstream bus status register
// ---------------------------------------------------------------
`define CBS_B_PAR        15
`define CBS_B_SERR       14
`define CBS_B_MABORT     13
`define CBS_B_RECTA      12
`define CBS_B_SIGTA      11
`define CBS_B_TIM_HI     10
`define CBS_B_TIM_LO     9
`define CBS_B_DPAR       8

// Read answer comes this many clocks after the request
`define CBS_ACK_LAT      1

`endif

// ---- shared/cbs_pkg.sv ----
package cbs_pkg;

	// Configuration access from the primary side
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [2:0]  func;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} cbs_cfg_req_type;

	// Downstream bus events, one cycle pulses
	typedef struct packed {
		logic addr_parity_err;
		logic data_parity_err;
		logic cserr_seen;
		logic master_abort;
		logic target_abort_rcvd;
		logic target_abort_sent;
		logic cperr_seen;
		logic master_of_phase;
	} cbs_event_type;

	// Clearable status flags
	typedef struct packed {
		logic downstream_parity_detected;
		logic card_system_error_seen;
		logic downstream_master_abort_received;
		logic downstream_target_abort_received;
		logic downstream_target_abort_signaled;
		logic downstream_data_parity_flag;
	} cbs_flags_type;

	// Forwarding query for a configuration cycle
	typedef struct packed {
		logic       valid;
		logic [2:0] func;
		logic [7:0] bus;
	} cbs_fwd_req_type;

	// State of one function copy
	typedef struct packed {
		cbs_flags_type flags;
		logic [7:0]    upstream_bus_number;
		logic [7:0]    cardbus_bus_number;
		logic [7:0]    highest_bus_number;
	} cbs_func_state_type;

	// State of the top level
	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic        pm_hit;
		logic        fwd_done;
		logic        fwd_cardbus;
		logic        fwd_below;
		logic        cserr_oe;
	} cbs_top_state_type;

endpackage

// ---- src/cbs_func_regs.sv ----
`timescale 1ns/10ps
`include "cbs_params.svh"

module cbs_func_regs (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire cbs_pkg::cbs_event_type      ev,
	input  wire logic                        perr_resp_en,
	input  wire logic [15:0]                 stat_clr,
	input  wire logic [2:0]                  bus_we,
	input  wire logic [23:0]                 bus_wdata,
	output cbs_pkg::cbs_func_state_type      st_r
);
	import cbs_pkg::*;

	cbs_func_state_type st_nxt;
	cbs_flags_type      set_v;
	cbs_flags_type      clr_v;

	// ---------------------------------------------------------------
	// Flag set and clear
	// ---------------------------------------------------------------
	// Set beats clear so an event in the clearing cycle is kept
	always_comb begin
		set_v.downstream_parity_detected =
			ev.addr_parity_err | ev.data_parity_err;
		set_v.card_system_error_seen = ev.cserr_seen;
		set_v.downstream_master_abort_received = ev.master_abort;
		set_v.downstream_target_abort_received =
			ev.target_abort_rcvd;
		set_v.downstream_target_abort_signaled =
			ev.target_abort_sent;
		set_v.downstream_data_parity_flag =
			ev.cperr_seen & ev.master_of_phase & perr_resp_en;
		clr_v.downstream_parity_detected = stat_clr[`CBS_B_PAR];
		clr_v.card_system_error_seen = stat_clr[`CBS_B_SERR];
		clr_v.downstream_master_abort_received = stat_clr[`CBS_B_MABORT];
		clr_v.downstream_target_abort_received = stat_clr[`CBS_B_RECTA];
		clr_v.downstream_target_abort_signaled = stat_clr[`CBS_B_SIGTA];
		clr_v.downstream_data_parity_flag = stat_clr[`CBS_B_DPAR];
		st_nxt = st_r;
		st_nxt.flags = (st_r.flags & ~clr_v) | set_v;
		if (bus_we[0]) begin
			st_nxt.upstream_bus_number = bus_wdata[7:0];
		end
		if (bus_we[1]) begin
			st_nxt.cardbus_bus_number = bus_wdata[15:8];
		end
		if (bus_we[2]) begin
			st_nxt.highest_bus_number = bus_wdata[23:16];
		end
	end

	// Reset flags clear and bus numbers zero
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_par_set;
		@(posedge clk) disable iff (rst)
		(ev.addr_parity_err || ev.data_parity_err)
			|=> st_r.flags.downstream_parity_detected;
	endproperty
	a_par_set: assert property (p_par_set)
		else $error("parity flag not set");

	property p_dpar_cause;
		@(posedge clk) disable iff (rst)
		$rose(st_r.flags.downstream_data_parity_flag)
			|-> $past(ev.cperr_seen && ev.master_of_phase && perr_resp_en);
	endproperty
	a_dpar_cause: assert property (p_dpar_cause)
		else $error("data parity flag set without all conditions");

	property p_clear_one;
		@(posedge clk) disable iff (rst)
		(stat_clr[`CBS_B_MABORT] && !ev.master_abort)
			|=> !st_r.flags.downstream_master_abort_received;
	endproperty
	a_clear_one: assert property (p_clear_one)
		else $error("write one did not clear flag");

	property p_keep_zero;
		@(posedge clk) disable iff (rst)
		(st_r.flags.card_system_error_seen && !stat_clr[`CBS_B_SERR])
			|=> st_r.flags.card_system_error_seen;
	endproperty
	a_keep_zero: assert property (p_keep_zero)
		else $error("flag lost without write one");

	property p_bus_write;
		@(posedge clk) disable iff (rst)
		bus_we[0] |=> st_r.upstream_bus_number == $past(bus_wdata[7:0]);
	endproperty
	a_bus_write: assert property (p_bus_write)
		else $error("upstream bus number not written");

	property p_set_wins;
		@(posedge clk) disable iff (rst)
		(ev.master_abort && stat_clr[`CBS_B_MABORT])
			|=> st_r.flags.downstream_master_abort_received;
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("event lost to a clear in the same cycle");

endmodule

// ---- src/cbs_status_regs.sv ----
// Function
// - Capability pointer reads A0h, writes ignored
// - Power management block at A0h and A4h
// - All functions share one constant capability pointer
// - Writing one clears a status flag
// - Status at 16h, resets to 0200h
// - Bit 15 set on downstream parity error
// - Bit 14 set on card error; never driven
// - Bit 13 set on received master abort
// - Bit 12 set on received target abort
// - Bit 11 set on signalled target abort
// - Bits 10 to 9 fixed at 01b
// - Bit 8 needs error, mastership and enable
// - Bits 7 to 5 hardwired zero
// - Reserved bits 4 to 0 read zero
// - Upstream bus number at 18h, reset zero
// - Forwarding uses all three bus numbers
// - Bus numbers at 19h and 1Ah, reset zero
`timescale 1ns/10ps
`include "cbs_params.svh"

module cbs_status_regs #(
	parameter int NUM_FUNC = 2
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire cbs_pkg::cbs_cfg_req_type cfg_req,
	output logic                         cfg_ack_r,
	output logic [31:0]                  cfg_rdata_r,
	output logic                         pm_hit_r,
	input  wire cbs_pkg::cbs_event_type  ev [NUM_FUNC],
	input  wire logic [NUM_FUNC-1:0]     perr_resp_en,
	input  wire cbs_pkg::cbs_fwd_req_type fwd_req,
	output logic                         fwd_done_r,
	output logic                         fwd_cardbus_r,
	output logic                         fwd_below_r,
	output logic                         cserr_oe_r
);
	import cbs_pkg::*;

	cbs_top_state_type  st_r;
	cbs_top_state_type  st_nxt;
	cbs_func_state_type fst [NUM_FUNC];
	logic [15:0]        stat_clr [NUM_FUNC];
	logic [2:0]         bus_we [NUM_FUNC];

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Dword hit test, byte lanes are taken from the enables
	function automatic logic dw_hit(input logic [7:0] a,
		input logic [7:0] off);
		dw_hit = (a[7:2] == off[7:2]);
	endfunction

	// Byte enable stretched over one lane
	function automatic logic [7:0] lane_mask(input logic b);
		lane_mask = {8{b}};
	endfunction

	// Assemble the readable status word from the flags
	function automatic logic [15:0] stat_word(input cbs_flags_type f);
		logic [15:0] w;
		w = 16'h0000;
		w[`CBS_B_PAR] = f.downstream_parity_detected;
		w[`CBS_B_SERR] = f.card_system_error_seen;
		w[`CBS_B_MABORT] = f.downstream_master_abort_received;
		w[`CBS_B_RECTA] = f.downstream_target_abort_received;
		w[`CBS_B_SIGTA] = f.downstream_target_abort_signaled;
		w[`CBS_B_TIM_HI:`CBS_B_TIM_LO] = `CBS_SEL_TIMING;
		w[`CBS_B_DPAR] = f.downstream_data_parity_flag;
		stat_word = w;
	endfunction

	// Inclusive range test for downstream buses
	function automatic logic in_range(input logic [7:0] b,
		input logic [7:0] lo, input logic [7:0] hi);
		in_range = (b >= lo) && (b <= hi);
	endfunction

	// Function number is mapped only when a copy exists
	function automatic logic func_ok(input logic [2:0] f);
		func_ok = ({29'h0, f} < NUM_FUNC);
	endfunction

	// ---------------------------------------------------------------
	// Write strobes per function copy
	// ---------------------------------------------------------------
	// Every enabled status bit reaches stat_clr; writes to fixed and
	// reserved bits fall away in cbs_func_regs
	always_comb begin
		for (int i = 0; i < NUM_FUNC; i++) begin
			stat_clr[i] = 16'h0000;
			bus_we[i] = 3'h0;
			if (cfg_req.valid && cfg_req.write &&
				cfg_req.func == i[2:0]) begin
				if (dw_hit(cfg_req.addr, `CBS_OFF_STAT)) begin
					stat_clr[i] = cfg_req.wdata[31:16] &
						{lane_mask(cfg_req.be[3]),
						lane_mask(cfg_req.be[2])};
				end else if (dw_hit(cfg_req.addr, `CBS_OFF_UPBUS)) begin
					bus_we[i] = cfg_req.be[2:0];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Function copies
	// ---------------------------------------------------------------
	// One copy each keeps the sockets fully independent
	for (genvar g = 0; g < NUM_FUNC; g++) begin : g_func
		cbs_func_regs u_regs (
			.clk          (clk),
			.rst          (rst),
			.ev           (ev[g]),
			.perr_resp_en (perr_resp_en[g]),
			.stat_clr     (stat_clr[g]),
			.bus_we       (bus_we[g]),
			.bus_wdata    (cfg_req.wdata[23:0]),
			.st_r         (fst[g])
		);
	end

	// ---------------------------------------------------------------
	// Read path, PM decode and forwarding decision
	// ---------------------------------------------------------------
	always_comb begin
		cbs_func_state_type rf;
		cbs_func_state_type qf;
		rf = '0;
		qf = '0;
		for (int i = 0; i < NUM_FUNC; i++) begin
			if (cfg_req.func == i[2:0]) begin
				rf = fst[i];
			end
			if (fwd_req.func == i[2:0]) begin
				qf = fst[i];
			end
		end
		st_nxt = st_r;
		st_nxt.ack = cfg_req.valid;
		st_nxt.rdata = 32'h0000_0000;
		st_nxt.pm_hit = 1'b0;
		st_nxt.cserr_oe = 1'b0;
		// Unmapped and write cycles answer with zero data
		if (cfg_req.valid && !cfg_req.write &&
			func_ok(cfg_req.func)) begin
			if (dw_hit(cfg_req.addr, `CBS_OFF_CAP)) begin
				// Capability pointer is a constant, no write path
				st_nxt.rdata = {stat_word(rf.flags), 8'h00,
					`CBS_CAP_VAL};
			end else if (dw_hit(cfg_req.addr, `CBS_OFF_UPBUS)) begin
				st_nxt.rdata = {8'h00, rf.highest_bus_number,
					rf.cardbus_bus_number,
					rf.upstream_bus_number};
			end
		end
		// PM registers live elsewhere; flag the hit for them
		if (cfg_req.valid && func_ok(cfg_req.func) &&
			(dw_hit(cfg_req.addr, `CBS_OFF_PM0) ||
			dw_hit(cfg_req.addr, `CBS_OFF_PM1))) begin
			st_nxt.pm_hit = 1'b1;
		end
		st_nxt.fwd_done = fwd_req.valid;
		st_nxt.fwd_cardbus = 1'b0;
		st_nxt.fwd_below = 1'b0;
		// Own bus number is never forwarded downstream
		if (fwd_req.valid && func_ok(fwd_req.func) &&
			fwd_req.bus != qf.upstream_bus_number) begin
			if (fwd_req.bus == qf.cardbus_bus_number) begin
				st_nxt.fwd_cardbus = 1'b1;
			end else if (in_range(fwd_req.bus, qf.cardbus_bus_number,
				qf.highest_bus_number)) begin
				st_nxt.fwd_below = 1'b1;
			end
		end
	end

	// Single register stage for all top outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state flops
	assign cfg_ack_r     = st_r.ack;
	assign cfg_rdata_r   = st_r.rdata;
	assign pm_hit_r      = st_r.pm_hit;
	assign fwd_done_r    = st_r.fwd_done;
	assign fwd_cardbus_r = st_r.fwd_cardbus;
	assign fwd_below_r   = st_r.fwd_below;
	assign cserr_oe_r    = st_r.cserr_oe;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_cap_read;
		cfg_req.valid && !cfg_req.write && func_ok(cfg_req.func) &&
			dw_hit(cfg_req.addr, `CBS_OFF_CAP);
	endsequence

	sequence s_cap_answer;
		cfg_ack_r && cfg_rdata_r[7:0] == `CBS_CAP_VAL;
	endsequence

	property p_cap_val;
		@(posedge clk) disable iff (rst)
		s_cap_read |=> s_cap_answer;
	endproperty
	a_cap_val: assert property (p_cap_val)
		else $error("capability pointer not A0h");

	property p_fixed_bits;
		@(posedge clk) disable iff (rst)
		s_cap_read |=> cfg_rdata_r[26:16] == 11'h200 ||
			cfg_rdata_r[26:16] == 11'h300;
	endproperty
	a_fixed_bits: assert property (p_fixed_bits)
		else $error("fixed status bits wrong");

	property p_ack_once;
		@(posedge clk) disable iff (rst)
		cfg_req.valid |=> cfg_ack_r;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("no answer one cycle after request");

	property p_no_cserr;
		@(posedge clk) disable iff (rst)
		!cserr_oe_r;
	endproperty
	a_no_cserr: assert property (p_no_cserr)
		else $error("card error line driven");

	property p_pm_hit;
		@(posedge clk) disable iff (rst)
		(cfg_req.valid && func_ok(cfg_req.func) &&
			cfg_req.addr[7:2] == `CBS_OFF_PM1 >> 2) |=> pm_hit_r;
	endproperty
	a_pm_hit: assert property (p_pm_hit)
		else $error("power management block not decoded");

	property p_fwd_own_bus;
		@(posedge clk) disable iff (rst)
		(fwd_req.valid && fwd_req.func == 3'h0 &&
			fwd_req.bus == fst[0].upstream_bus_number)
			|=> !fwd_cardbus_r && !fwd_below_r;
	endproperty
	a_fwd_own_bus: assert property (p_fwd_own_bus)
		else $error("own bus forwarded downstream");

	property p_fwd_range;
		@(posedge clk) disable iff (rst)
		(fwd_req.valid && fwd_req.func == 3'h0 &&
			fwd_req.bus != fst[0].upstream_bus_number &&
			fwd_req.bus > fst[0].cardbus_bus_number &&
			fwd_req.bus <= fst[0].highest_bus_number)
			|=> fwd_below_r ##1 !fwd_below_r || fwd_done_r;
	endproperty
	a_fwd_range: assert property (p_fwd_range)
		else $error("in range cycle not forwarded");

	property p_reset_stat;
		@(posedge clk)
		($fell(rst) && cfg_req.valid && !cfg_req.write &&
			func_ok(cfg_req.func) && dw_hit(cfg_req.addr, `CBS_OFF_CAP))
			|=> cfg_rdata_r[31:16] == `CBS_STAT_RST;
	endproperty
	a_reset_stat: assert property (p_reset_stat)
		else $error("status reset value wrong");

	// Answer stands one cycle only, data falls back to zero
	property p_ack_pulse;
		@(posedge clk) disable iff (rst)
		!cfg_req.valid |=> !cfg_ack_r && !pm_hit_r && cfg_rdata_r == 32'h0;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("answer stood longer than one cycle");

	property p_write_no_data;
		@(posedge clk) disable iff (rst)
		(cfg_req.valid && cfg_req.write) |=> cfg_rdata_r == 32'h0;
	endproperty
	a_write_no_data: assert property (p_write_no_data)
		else $error("write answered with data");

	property p_unmapped_func;
		@(posedge clk) disable iff (rst)
		(cfg_req.valid && !func_ok(cfg_req.func))
			|=> cfg_rdata_r == 32'h0 && !pm_hit_r;
	endproperty
	a_unmapped_func: assert property (p_unmapped_func)
		else $error("missing function answered");

	property p_pm0_hit;
		@(posedge clk) disable iff (rst)
		(cfg_req.valid && func_ok(cfg_req.func) &&
			dw_hit(cfg_req.addr, `CBS_OFF_PM0)) |=> pm_hit_r;
	endproperty
	a_pm0_hit: assert property (p_pm0_hit)
		else $error("first power management dword not decoded");

	property p_pm_only;
		@(posedge clk) disable iff (rst)
		(cfg_req.valid && !dw_hit(cfg_req.addr, `CBS_OFF_PM0) &&
			!dw_hit(cfg_req.addr, `CBS_OFF_PM1)) |=> !pm_hit_r;
	endproperty
	a_pm_only: assert property (p_pm_only)
		else $error("power management hit outside its block");

	// Flag positions checked against the stored copy, not the packer
	property p_stat_flags;
		@(posedge clk) disable iff (rst)
		(cfg_req.valid && !cfg_req.write && cfg_req.func == 3'h0 &&
			dw_hit(cfg_req.addr, `CBS_OFF_CAP))
			|=> {cfg_rdata_r[31:27], cfg_rdata_r[24]} == $past(fst[0].flags);
	endproperty
	a_stat_flags: assert property (p_stat_flags)
		else $error("status flags read back wrong");

	property p_bus_read;
		@(posedge clk) disable iff (rst)
		(cfg_req.valid && !cfg_req.write && cfg_req.func == 3'h0 &&
			dw_hit(cfg_req.addr, `CBS_OFF_UPBUS))
			|=> cfg_rdata_r == {8'h00, $past(fst[0].highest_bus_number),
				$past(fst[0].cardbus_bus_number),
				$past(fst[0].upstream_bus_number)};
	endproperty
	a_bus_read: assert property (p_bus_read)
		else $error("bus numbers read back wrong");

	property p_fwd_done;
		@(posedge clk) disable iff (rst)
		fwd_req.valid |=> fwd_done_r;
	endproperty
	a_fwd_done: assert property (p_fwd_done)
		else $error("forward query not answered");

	property p_fwd_idle;
		@(posedge clk) disable iff (rst)
		!fwd_req.valid |=> !fwd_done_r && !fwd_cardbus_r && !fwd_below_r;
	endproperty
	a_fwd_idle: assert property (p_fwd_idle)
		else $error("forward result without a query");

	property p_fwd_cardbus;
		@(posedge clk) disable iff (rst)
		(fwd_req.valid && fwd_req.func == 3'h0 &&
			fwd_req.bus != fst[0].upstream_bus_number &&
			fwd_req.bus == fst[0].cardbus_bus_number)
			|=> fwd_cardbus_r && !fwd_below_r;
	endproperty
	a_fwd_cardbus: assert property (p_fwd_cardbus)
		else $error("cycle for the card bus not claimed");

	// A card bus number above the highest still claims its own bus
	property p_fwd_outside;
		@(posedge clk) disable iff (rst)
		(fwd_req.valid && fwd_req.func == 3'h0 &&
			fwd_req.bus != fst[0].cardbus_bus_number &&
			(fwd_req.bus < fst[0].cardbus_bus_number ||
			fwd_req.bus > fst[0].highest_bus_number))
			|=> !fwd_cardbus_r && !fwd_below_r;
	endproperty
	a_fwd_outside: assert property (p_fwd_outside)
		else $error("out of range cycle forwarded");

	property p_fwd_unmapped;
		@(posedge clk) disable iff (rst)
		(fwd_req.valid && !func_ok(fwd_req.func))
			|=> fwd_done_r && !fwd_cardbus_r && !fwd_below_r;
	endproperty
	a_fwd_unmapped: assert property (p_fwd_unmapped)
		else $error("missing function forwarded");

endmodule

// ---- test/cbs_card_model.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Card side: raises downstream bus events on command
// ------------------------------------------------------------
module cbs_card_model (
	input  wire logic                   cmd_valid,
	input  wire logic [2:0]             cmd_func,
	input  wire cbs_pkg::cbs_event_type cmd_ev,
	output cbs_pkg::cbs_event_type      ev [2]
);
	import cbs_pkg::*;

	// Only the addressed socket sees the event; others stay quiet
	always_comb begin
		for (int f = 0; f < 2; f++) begin
			ev[f] = (cmd_valid && cmd_func == 3'(f)) ? cmd_ev : '0;
		end
	end
endmodule

// ---- test/cbs_status_regs_tb.sv ----
`timescale 1ns/10ps
module cbs_status_regs_tb;
	import cbs_pkg::*;

	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic            clk          = 1'b0;
	logic            rst          = 1'b1;
	cbs_cfg_req_type cfg_req      = '0;
	cbs_fwd_req_type fwd_req      = '0;
	logic [1:0]      perr_resp_en = 2'h0;
	logic            cmd_valid    = 1'b0;
	logic [2:0]      cmd_func     = 3'h0;
	cbs_event_type   cmd_ev       = '0;
	cbs_event_type   ev_w [2];
	logic            ack;
	logic            pm_hit;
	logic            fwd_done;
	logic            fwd_cb;
	logic            fwd_below;
	logic            cserr_oe;
	logic [31:0]     rdata;
	logic [31:0]     rd;
	logic            pm;
	logic [7:0]      bm [2][3];
	int              err_total    = 0;
	int              comparisons  = 0;

	// 8 ns period
	always #4 clk = ~clk;

	cbs_status_regs #(.NUM_FUNC(2)) dut (
		.clk          (clk),
		.rst          (rst),
		.cfg_req      (cfg_req),
		.cfg_ack_r    (ack),
		.cfg_rdata_r  (rdata),
		.pm_hit_r     (pm_hit),
		.ev           (ev_w),
		.perr_resp_en (perr_resp_en),
		.fwd_req      (fwd_req),
		.fwd_done_r   (fwd_done),
		.fwd_cardbus_r(fwd_cb),
		.fwd_below_r  (fwd_below),
		.cserr_oe_r   (cserr_oe)
	);

	cbs_card_model card (
		.cmd_valid(cmd_valid),
		.cmd_func (cmd_func),
		.cmd_ev   (cmd_ev),
		.ev       (ev_w)
	);

	// ------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			err_total++;
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Answer is fixed at one cycle, so no open wait is needed
	task automatic cfg(input logic w, input logic [2:0] fn,
		input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
		cfg_req = '{1'b1, w, fn, a, be, wd};
		@(negedge clk);
		cfg_req.valid = 1'b0;
		rd = rdata;
		pm = pm_hit;
		chk({31'h0, ack}, 32'h1);
		chk({31'h0, cserr_oe}, 32'h0);
		// Idle cycle between requests; the answer must not linger
		@(negedge clk);
		chk({31'h0, ack}, 32'h0);
		chk(rdata, 32'h0);
	endtask

	task automatic fwd(input logic [2:0] fn, input logic [7:0] b,
		input logic [1:0] exp);
		fwd_req = '{1'b1, fn, b};
		@(negedge clk);
		fwd_req.valid = 1'b0;
		chk({29'h0, fwd_done, fwd_cb, fwd_below}, {29'h0, 1'b1, exp});
		@(negedge clk);
		chk({29'h0, fwd_done, fwd_cb, fwd_below}, 32'h0);
	endtask

	task automatic fire(input logic [2:0] fn, input cbs_event_type e);
		cmd_func = fn;
		cmd_ev = e;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask

	// Flags a given event pulse ought to leave behind
	function automatic logic [15:0] flag_of(cbs_event_type e, logic pen);
		flag_of = 16'h0000;
		flag_of[15] = e.addr_parity_err | e.data_parity_err;
		flag_of[14] = e.cserr_seen;
		flag_of[13] = e.master_abort;
		flag_of[12] = e.target_abort_rcvd;
		flag_of[11] = e.target_abort_sent;
		flag_of[8] = e.cperr_seen & e.master_of_phase & pen;
	endfunction

	// Own bus claims nothing, ahead of the range test
	function automatic logic [1:0] fwd_of(logic [7:0] p, logic [7:0] c,
		logic [7:0] s, logic [7:0] b);
		if (b == p) begin
			return 2'b00;
		end
		return {b == c, b > c && b <= s};
	endfunction

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [2:0]    fn;
		logic [3:0]    be;
		logic [31:0]   wd;
		logic [15:0]   m;
		cbs_event_type e;
		logic [7:0]    pr [6];
		void'($urandom(32'h889e3cac));
		bm = '{default: 8'h00};
		repeat (4) @(negedge clk);
		rst = 1'b0;
		for (int f = 0; f < 2; f++) begin
			cfg(0, 3'(f), 8'h14, 4'hf, 32'h0);
			chk(rd, 32'h0200_00a0);
			cfg(0, 3'(f), 8'h18, 4'hf, 32'h0);
			chk(rd, 32'h0);
		end
		$display("test reset values done");
		cfg(0, 3'd1, 8'ha0, 4'hf, 32'h0);
		chk({31'h0, pm}, 32'h1);
		cfg(0, 3'd0, 8'ha4, 4'hf, 32'h0);
		chk({31'h0, pm}, 32'h1);
		cfg(0, 3'd0, 8'h1c, 4'hf, 32'h0);
		chk({rd[31:1], pm}, 32'h0);
		cfg(0, 3'd3, 8'h14, 4'hf, 32'h0);
		chk(rd, 32'h0);
		cfg(1, 3'd0, 8'h14, 4'hf, 32'hffff_ffff);
		cfg(0, 3'd0, 8'h14, 4'hf, 32'h0);
		chk(rd, 32'h0200_00a0);
		$display("test map done");
		// Random card events, then two no-op writes and a real clear
		for (int i = 0; i < 40; i++) begin
			fn = 3'($urandom % 2);
			e = cbs_event_type'(8'($urandom));
			perr_resp_en = 2'($urandom);
			m = flag_of(e, perr_resp_en[fn[0]]);
			fire(fn, e);
			cfg(0, fn, 8'h14, 4'hf, 32'h0);
			chk(rd, {16'h0200 | m, 16'h00a0});
			cfg(0, 3'd1 - fn, 8'h14, 4'hf, 32'h0);
			chk(rd, 32'h0200_00a0);
			cfg(1, fn, 8'h14, 4'h7, 32'hffff_ffff);
			cfg(1, fn, 8'h16, 4'h8, 32'h0);
			cfg(0, fn, 8'h16, 4'hf, 32'h0);
			chk(rd, {16'h0200 | m, 16'h00a0});
			cfg(1, fn, 8'h16, 4'h8, {m, 16'h0});
			cfg(0, fn, 8'h14, 4'hf, 32'h0);
			chk(rd, 32'h0200_00a0);
		end
		// Event in the clearing cycle survives the clear
		cmd_ev = '{master_abort: 1'b1, default: 1'b0};
		cmd_func = 3'd0;
		cmd_valid = 1'b1;
		cfg_req = '{1'b1, 1'b1, 3'd0, 8'h16, 4'h8, 32'hff00_0000};
		@(negedge clk);
		cmd_valid = 1'b0;
		cfg_req.valid = 1'b0;
		chk({31'h0, ack}, 32'h1);
		@(negedge clk);
		cfg(0, 3'd0, 8'h14, 4'hf, 32'h0);
		chk(rd, 32'h2200_00a0);
		cfg(1, 3'd0, 8'h16, 4'h8, 32'hff00_0000);
		cfg(0, 3'd0, 8'h14, 4'hf, 32'h0);
		chk(rd, 32'h0200_00a0);
		$display("test status flags done");
		// Bus numbers by byte lane, then forwarding at the edges
		for (int i = 0; i < 20; i++) begin
			fn = 3'($urandom % 2);
			be = 4'($urandom);
			wd = $urandom;
			for (int k = 0; k < 3; k++) begin
				if (be[k]) begin
					bm[fn[0]][k] = wd[8*k +: 8];
				end
			end
			cfg(1, fn, 8'h18, be, wd);
			cfg(0, fn, 8'h18, 4'hf, 32'h0);
			chk(rd, {8'h00, bm[fn[0]][2], bm[fn[0]][1],
				bm[fn[0]][0]});
			pr = '{bm[fn[0]][0], bm[fn[0]][1], bm[fn[0]][2],
				bm[fn[0]][2] + 8'h01, bm[fn[0]][1] + 8'h01, 8'($urandom)};
			for (int j = 0; j < 6; j++) begin
				fwd(fn, pr[j], fwd_of(bm[fn[0]][0], bm[fn[0]][1],
					bm[fn[0]][2], pr[j]));
			end
			fwd(3'd2, pr[1], 2'b00);
		end
		// Mid-run reset drops set flags and programmed bus numbers
		fire(fn, cbs_event_type'(8'hff));
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		bm = '{default: 8'h00};
		cfg(0, fn, 8'h14, 4'hf, 32'h0);
		chk(rd, 32'h0200_00a0);
		cfg(0, fn, 8'h18, 4'hf, 32'h0);
		chk(rd, 32'h0);
		$display("test bus numbers done");
		tally_and_finish();
	end
endmodule
